/* src/pdc_config_regs.sv */
// pdc_config_regs: clock multiplier, delay loop and double-buffered offset
// configuration bank behind an AHB-Lite slave.
// assumes a single 25 MHz clock; analog loops live outside and take the
// decoded fields below as plain levels.
// the channel inputs share the bus clock, so no synchronisers sit in front of them.
// working offsets are two's complement and sign-extended to the datapath width.
// software owns every bit here; the bank never rewrites a register by itself.
// reads return the byte in bits 7:0 and zero above; bus errors are never raised.
//
// Notes on behaviour
// - multiplier field is thermometer code giving 1..32; other patterns flagged invalid.
// - reference divider field is thermometer code giving 1..8; others flagged invalid.
// - manual delay is signed 5 degree steps around 90, from 50 to 125.
// - inversion bit set inverts the internal delay-loop clock.
// - bias codes 011 max, 000 mid, 101 min; code 100 flagged forbidden.
// - discharge bit high holds the multiplier loop filter discharged.
// - halving bit selects half oscillator frequency, else full.
// - oscillator gain is two bits at 5:4 of the tuning register.
// - range field is four bits at 3:0 and sets oscillator bias, 0000 lowest up to 1111 highest.
// - rising edge of sync bit copies both 13-bit offsets to working registers.
// - sync bit keeps its written value; hardware never clears it.
// - channel A offset is low five bits of sync register plus low byte.
// - enable bit adds working offsets into the channel datapaths.
// - channel B offset split in two registers, loaded by same sync edge.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module pdc_config_regs
    import pdc_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // clock multiplier controls
    output logic [5:0] MULT_FACTOR,
    output logic [3:0] REFDIV_FACTOR,
    output logic DIVIDER_INVALID,
    output logic LOOP_FILTER_DISCHARGE,
    output logic OSCILLATOR_HALVING,
    output logic [1:0] OSC_GAIN,
    output logic [3:0] OSC_RANGE,
    // delay loop controls
    output logic [3:0] DELAY_CODE,
    output logic [7:0] DELAY_DEGREES,
    output logic DELAY_CLOCK_INVERT,
    output logic [2:0] DELAY_BIAS,
    output logic BIAS_FORBIDDEN_SEL,
    // channel datapaths
    input wire logic [DATA_W-1:0] CH_A_IN,
    input wire logic [DATA_W-1:0] CH_B_IN,
    output logic [DATA_W-1:0] CH_A_OUT,
    output logic [DATA_W-1:0] CH_B_OUT
);
    import pdc_pkg::*;

    pdc_wr_if wr ();
    logic [4:0] rd_index;
    logic [7:0] rd_byte;

    // stored configuration registers; reserved bits kept as written
    logic [7:0] dividers;
    logic [7:0] delay_setup;
    logic [7:0] tuning;

    // programmed offsets, offset enable and the sync edge tracker
    logic [7:0] sync_a_high;
    logic [7:0] a_low;
    logic [7:0] b_high;
    logic [7:0] b_low;
    logic [7:0] control;
    logic sync_prev;

    // working offsets seen by the channel adders
    logic [OFFSET_W-1:0] channel_a_offset;
    logic [OFFSET_W-1:0] channel_b_offset;

    // bus slave: zero wait states, a write lands at the end of its data phase
    pdc_ahb_slave bus (
        .clock(CLOCK),
        .rst_n(RST_N),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hsize(HSIZE),
        .hwdata(HWDATA),
        .hready(HREADY),
        .hrdata(HRDATA),
        .hreadyout(HREADYOUT),
        .hresp(HRESP),
        .wr(wr.source),
        .rd_index(rd_index),
        .rd_byte(rd_byte)
    );

    // write decode per register
    // one strobe per cycle, so no two registers ever take the same write
    // writes to read-only or unmapped indices match nothing here and are dropped
    wire wr_dividers = wr.strobe && (wr.index == IDX_DIVIDERS);
    wire wr_delay = wr.strobe && (wr.index == IDX_DELAY);
    wire wr_tuning = wr.strobe && (wr.index == IDX_TUNING);
    wire wr_sync = wr.strobe && (wr.index == IDX_SYNC_A_HIGH);
    wire wr_a_low = wr.strobe && (wr.index == IDX_A_LOW);
    wire wr_b_high = wr.strobe && (wr.index == IDX_B_HIGH);
    wire wr_b_low = wr.strobe && (wr.index == IDX_B_LOW);
    wire wr_control = wr.strobe && (wr.index == IDX_CONTROL);

    // configuration storage; codes kept as written, no correction
    // an invalid divider code stays visible on readback so software can see it
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            dividers <= RST_DIVIDERS;
            delay_setup <= RST_DELAY;
            tuning <= RST_TUNING;
        end else begin
            if (wr_dividers) dividers <= wr.data;
            if (wr_delay) delay_setup <= wr.data;
            if (wr_tuning) tuning <= wr.data;
        end
    end

    // programmed offsets; the sync bit is only ever changed by software
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sync_a_high <= RST_SYNC_A_HIGH;
            a_low <= RST_A_LOW;
            b_high <= RST_B_HIGH;
            b_low <= RST_B_LOW;
            control <= RST_CONTROL;
        end else begin
            if (wr_sync) sync_a_high <= wr.data;
            if (wr_a_low) a_low <= wr.data;
            if (wr_b_high) b_high <= wr.data;
            if (wr_b_low) b_low <= wr.data;
            if (wr_control) control <= wr.data;
        end
    end

    // programmed 13-bit values assembled from high and low registers
    // the two halves may be written in any order; nothing moves before sync
    wire [OFFSET_W-1:0] prog_a = {sync_a_high[OFFSET_HIGH_LSB +: 5], a_low};
    wire [OFFSET_W-1:0] prog_b = {b_high[OFFSET_HIGH_LSB +: 5], b_low};
    wire sync_bit = sync_a_high[SYNC_BIT];
    wire sync_rise = sync_bit && !sync_prev;

    // double buffer: working values move only on a rising sync edge
    // sync_prev resets low, so a bit written high straight after reset still loads
    // rewriting the bit high without clearing it first loads nothing: no edge, no copy
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sync_prev <= 1'b0;
            channel_a_offset <= 13'h0000;
            channel_b_offset <= 13'h0000;
        end else begin
            sync_prev <= sync_bit;
            if (sync_rise) begin
                channel_a_offset <= prog_a;
                channel_b_offset <= prog_b;
            end
        end
    end

    // multiplier thermometer decode
    // a broken code decodes to zero so the loop sees no usable factor
    wire [4:0] mult_code = dividers[MULT_LSB +: 5];
    wire [2:0] refdiv_code = dividers[REFDIV_LSB +: 3];
    logic [5:0] next_mult;
    logic [3:0] next_refdiv;
    logic mult_bad;
    logic refdiv_bad;
    always_comb begin
        mult_bad = 1'b0;
        case (mult_code)
            MULT_X1: next_mult = 6'h01;
            MULT_X2: next_mult = 6'h02;
            MULT_X4: next_mult = 6'h04;
            MULT_X8: next_mult = 6'h08;
            MULT_X16: next_mult = 6'h10;
            MULT_X32: next_mult = 6'h20;
            default: begin
                next_mult = 6'h00;
                mult_bad = 1'b1;
            end
        endcase
    end

    // reference divider thermometer decode
    // same policy as the multiplier: flag it, never repair it
    always_comb begin
        refdiv_bad = 1'b0;
        case (refdiv_code)
            REFDIV_X1: next_refdiv = 4'h1;
            REFDIV_X2: next_refdiv = 4'h2;
            REFDIV_X4: next_refdiv = 4'h4;
            REFDIV_X8: next_refdiv = 4'h8;
            default: begin
                next_refdiv = 4'h0;
                refdiv_bad = 1'b1;
            end
        endcase
    end

    // manual delay: code is two's complement steps around the centre
    // cut to eight bits on purpose: the result stays between 50 and 125
    wire [3:0] delay_code = delay_setup[DELAY_LSB +: 4];
    wire [7:0] delay_steps = {{4{delay_code[3]}}, delay_code};
    wire [7:0] delay_prod = 8'(delay_steps * DELAY_STEP_DEG);
    wire [7:0] next_degrees = 8'(DELAY_CENTRE_DEG + delay_prod);
    wire [2:0] bias_code = delay_setup[BIAS_LSB +: 3];

    // decoded controls registered so outputs come from flip-flops
    // costs one cycle after a write; the raw fields below follow at once
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            MULT_FACTOR <= 6'h01;
            REFDIV_FACTOR <= 4'h1;
            DIVIDER_INVALID <= 1'b0;
            DELAY_DEGREES <= DELAY_CENTRE_DEG;
            BIAS_FORBIDDEN_SEL <= 1'b0;
        end else begin
            MULT_FACTOR <= next_mult;
            REFDIV_FACTOR <= next_refdiv;
            DIVIDER_INVALID <= mult_bad || refdiv_bad;
            DELAY_DEGREES <= next_degrees;
            BIAS_FORBIDDEN_SEL <= (bias_code == BIAS_FORBIDDEN);
        end
    end

    // raw field outputs straight from the stored registers
    // levels, not pulses: discharge holds as long as software leaves the bit set
    assign LOOP_FILTER_DISCHARGE = tuning[DISCHARGE_BIT];
    assign OSCILLATOR_HALVING = tuning[HALVING_BIT];
    assign OSC_GAIN = tuning[GAIN_LSB +: 2];
    assign OSC_RANGE = tuning[RANGE_LSB +: 4];
    assign DELAY_CODE = delay_code;
    assign DELAY_CLOCK_INVERT = delay_setup[INVCLK_BIT];
    assign DELAY_BIAS = bias_code;

    // per-channel offset adders, index 0 channel A and index 1 channel B
    // wraps on overflow, saturation left to the datapath owner
    localparam int CHANNELS = 2;
    wire offset_on = control[ENABLE_BIT];
    wire [OFFSET_W-1:0] work_offset [CHANNELS];
    wire [DATA_W-1:0] chan_in [CHANNELS];
    assign work_offset[0] = channel_a_offset;
    assign work_offset[1] = channel_b_offset;
    assign chan_in[0] = CH_A_IN;
    assign chan_in[1] = CH_B_IN;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        logic [DATA_W-1:0] chan_out;
        wire [DATA_W-1:0] addend = DATA_W'({{(DATA_W-OFFSET_W){work_offset[ch][OFFSET_W-1]}}, work_offset[ch]});
        // the enable selects at the flop input, so switching it takes one cycle
        always_ff @(posedge CLOCK) begin
            if (!RST_N) begin
                chan_out <= '0;
            end else begin
                chan_out <= offset_on ? DATA_W'(chan_in[ch] + addend) : chan_in[ch];
            end
        end
    end

    // outputs straight from the per-channel flops
    assign CH_A_OUT = g_chan[0].chan_out;
    assign CH_B_OUT = g_chan[1].chan_out;

    // read mux; status shows invalid codes and sync edge tracker
    // working offsets show only their top five bits; the status word is read-only
    wire [7:0] status = {5'h00, BIAS_FORBIDDEN_SEL, sync_prev, DIVIDER_INVALID};
    always_comb begin
        case (rd_index)
            IDX_DIVIDERS: rd_byte = dividers;
            IDX_DELAY: rd_byte = delay_setup;
            IDX_TUNING: rd_byte = tuning;
            IDX_SYNC_A_HIGH: rd_byte = sync_a_high;
            IDX_A_LOW: rd_byte = a_low;
            IDX_B_HIGH: rd_byte = b_high;
            IDX_B_LOW: rd_byte = b_low;
            IDX_CONTROL: rd_byte = control;
            IDX_STATUS: rd_byte = status;
            IDX_WORK_A: rd_byte = {3'h0, channel_a_offset[OFFSET_W-1:8]};
            IDX_WORK_B: rd_byte = {3'h0, channel_b_offset[OFFSET_W-1:8]};
            default: rd_byte = 8'h00;
        endcase
    end
endmodule

/* shared/pdc_pkg.sv */
// pdc_pkg: register map, field layout, reset values and decode codes of the
// clock multiplier, delay loop and offset configuration bank.
// assumes a 32-bit AHB-Lite slave with one aligned word per register.
package pdc_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [4:0] IDX_DIVIDERS = 5'h09;
    localparam logic [4:0] IDX_DELAY = 5'h0A;
    localparam logic [4:0] IDX_TUNING = 5'h0B;
    localparam logic [4:0] IDX_SYNC_A_HIGH = 5'h0C;
    localparam logic [4:0] IDX_A_LOW = 5'h0D;
    localparam logic [4:0] IDX_B_HIGH = 5'h0E;
    localparam logic [4:0] IDX_B_LOW = 5'h0F;
    localparam logic [4:0] IDX_CONTROL = 5'h10;
    localparam logic [4:0] IDX_STATUS = 5'h11;
    localparam logic [4:0] IDX_WORK_A = 5'h12;
    localparam logic [4:0] IDX_WORK_B = 5'h13;
    // reset values
    localparam logic [7:0] RST_DIVIDERS = 8'h00;
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [7:0] RST_TUNING = 8'h00;
    localparam logic [7:0] RST_SYNC_A_HIGH = 8'h00;
    localparam logic [7:0] RST_A_LOW = 8'h00;
    localparam logic [7:0] RST_B_HIGH = 8'h00;
    localparam logic [7:0] RST_B_LOW = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    // field positions
    localparam int MULT_LSB = 3;
    localparam int REFDIV_LSB = 0;
    localparam int DELAY_LSB = 4;
    localparam int INVCLK_BIT = 3;
    localparam int BIAS_LSB = 0;
    localparam int DISCHARGE_BIT = 7;
    localparam int HALVING_BIT = 6;
    localparam int GAIN_LSB = 4;
    localparam int RANGE_LSB = 0;
    localparam int SYNC_BIT = 5;
    localparam int OFFSET_HIGH_LSB = 0;
    localparam int ENABLE_BIT = 0;
    localparam int OFFSET_W = 13;
    // thermometer codes of the feedback multiplier
    localparam logic [4:0] MULT_X1 = 5'h00;
    localparam logic [4:0] MULT_X2 = 5'h01;
    localparam logic [4:0] MULT_X4 = 5'h03;
    localparam logic [4:0] MULT_X8 = 5'h07;
    localparam logic [4:0] MULT_X16 = 5'h0F;
    localparam logic [4:0] MULT_X32 = 5'h1F;
    // thermometer codes of the reference divider
    localparam logic [2:0] REFDIV_X1 = 3'h0;
    localparam logic [2:0] REFDIV_X2 = 3'h1;
    localparam logic [2:0] REFDIV_X4 = 3'h3;
    localparam logic [2:0] REFDIV_X8 = 3'h7;
    // delay-line bias codes
    localparam logic [2:0] BIAS_MID = 3'h0;
    localparam logic [2:0] BIAS_MAX = 3'h3;
    localparam logic [2:0] BIAS_FORBIDDEN = 3'h4;
    localparam logic [2:0] BIAS_MIN = 3'h5;
    // manual delay: 90 degrees at code zero, 5 degree steps
    localparam logic [7:0] DELAY_CENTRE_DEG = 8'h5A;
    localparam logic [7:0] DELAY_STEP_DEG = 8'h05;
endpackage

/* shared/pdc_wr_if.sv */
// pdc_wr_if: one register write strobe with its index and byte, passed from
// the bus slave to the register bank.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pdc_wr_if;
    logic strobe;
    logic [4:0] index;
    logic [7:0] data;
    modport source (output strobe, output index, output data);
    modport sink (input strobe, input index, input data);
endinterface

/* src/pdc_ahb_slave.sv */
// pdc_ahb_slave: AHB-Lite word slave that turns accepted write transfers into
// byte writes and serves reads from a combinational read word.
// assumes one master, single word transfers; always ready, always OKAY.
`timescale 1ns/1ps
module pdc_ahb_slave (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // register side
    pdc_wr_if.source wr,
    output logic [4:0] rd_index,
    input wire logic [7:0] rd_byte
);
    logic wr_pend;
    logic rd_pend;
    logic [4:0] addr_q;
    logic [31:0] next_hrdata;
    // a transfer is taken when selected, active and the bus is ready
    wire take = hsel && hready && htrans[1];
    wire [4:0] take_index = haddr[6:2];
    wire word_ok = (haddr[1:0] == 2'h0) && (hsize == 3'h2) && (haddr[31:7] == 25'h0);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // write lands one cycle after the address phase, when hwdata stands
    assign wr.strobe = wr_pend;
    assign wr.index = addr_q;
    assign wr.data = hwdata[7:0];
    assign rd_index = take_index;
    assign next_hrdata = (take && !hwrite && word_ok) ? {24'h000000, rd_byte} : 32'h00000000;

    // address phase capture
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 5'h00;
        end else begin
            wr_pend <= take && hwrite && word_ok;
            rd_pend <= take && !hwrite;
            addr_q <= take_index;
        end
    end

    // read data registered at the end of the address phase
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (take || rd_pend) begin
            hrdata <= next_hrdata;
        end
    end
endmodule

/* tb/pdc_checker.sv */
// pdc_checker: bus and decode relations of the configuration bank.
// assumes one clock and a synchronous active-low reset; sees top ports only.
`timescale 1ns/1ps
module pdc_checker
    import pdc_pkg::*;
(
    // clock, reset and bus
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // decoded controls
    input wire logic [5:0] MULT_FACTOR,
    input wire logic [3:0] REFDIV_FACTOR,
    input wire logic DIVIDER_INVALID,
    input wire logic LOOP_FILTER_DISCHARGE,
    input wire logic OSCILLATOR_HALVING,
    input wire logic [1:0] OSC_GAIN,
    input wire logic [3:0] OSC_RANGE,
    input wire logic [3:0] DELAY_CODE,
    input wire logic [7:0] DELAY_DEGREES,
    input wire logic DELAY_CLOCK_INVERT,
    input wire logic [2:0] DELAY_BIAS,
    input wire logic BIAS_FORBIDDEN_SEL
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    // address phase of a write to one index, then its data phase
    sequence wr_to(logic [4:0] idx);
        HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == {25'h0, idx, 2'h0} ##1 1'b1;
    endsequence

    // own thermometer decoders, kept apart from the design's
    function automatic logic [5:0] m_dec(logic [4:0] c);
        case (c)
            5'h00: return 6'h01;
            5'h01: return 6'h02;
            5'h03: return 6'h04;
            5'h07: return 6'h08;
            5'h0F: return 6'h10;
            5'h1F: return 6'h20;
            default: return 6'h00;
        endcase
    endfunction

    function automatic logic [3:0] n_dec(logic [2:0] c);
        case (c)
            3'h0: return 4'h1;
            3'h1: return 4'h2;
            3'h3: return 4'h4;
            3'h7: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction

    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus slave not ready or not okay");
    divider_decode_a: assert property (
        wr_to(IDX_DIVIDERS) |=> ##1 MULT_FACTOR == m_dec($past(HWDATA[7:3], 2))
            && REFDIV_FACTOR == n_dec($past(HWDATA[2:0], 2)))
        else $error("divider factors do not follow written codes");
    invalid_flag_a: assert property (
        DIVIDER_INVALID == (MULT_FACTOR == 6'h00 || REFDIV_FACTOR == 4'h0))
        else $error("invalid flag disagrees with factors");
    degrees_map_a: assert property (
        $stable(DELAY_CODE) |-> DELAY_DEGREES == 8'(8'h5A + 8'h05 * {{4{DELAY_CODE[3]}}, DELAY_CODE}))
        else $error("delay degrees off the 5 degree scale");
    bias_forbid_a: assert property (
        $stable(DELAY_BIAS) |-> BIAS_FORBIDDEN_SEL == (DELAY_BIAS == 3'h4))
        else $error("forbidden bias flag wrong");
    delay_write_a: assert property (
        wr_to(IDX_DELAY) |=> {DELAY_CODE, DELAY_CLOCK_INVERT, DELAY_BIAS} == $past(HWDATA[7:0]))
        else $error("delay fields do not follow write");
    tuning_write_a: assert property (
        wr_to(IDX_TUNING) |=> {LOOP_FILTER_DISCHARGE, OSCILLATOR_HALVING, OSC_GAIN, OSC_RANGE}
            == $past(HWDATA[7:0]))
        else $error("tuning fields do not follow write");
endmodule

bind pdc_config_regs pdc_checker chk (.CLOCK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
    .HREADY, .HREADYOUT, .HRESP, .MULT_FACTOR, .REFDIV_FACTOR, .DIVIDER_INVALID,
    .LOOP_FILTER_DISCHARGE, .OSCILLATOR_HALVING, .OSC_GAIN, .OSC_RANGE, .DELAY_CODE,
    .DELAY_DEGREES, .DELAY_CLOCK_INVERT, .DELAY_BIAS, .BIAS_FORBIDDEN_SEL);

/* tb/testbench.sv */
// testbench: drives the configuration bank over AHB-Lite and checks outputs.
// assumes a zero-wait slave but still waits on ready with a bound.
`timescale 1ns/1ps
module testbench;
    import pdc_pkg::*;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic HREADY, HREADYOUT, HRESP;
    logic [31:0] HRDATA, rd;
    logic [5:0] MULT_FACTOR;
    logic [3:0] REFDIV_FACTOR, OSC_RANGE, DELAY_CODE;
    logic DIVIDER_INVALID, LOOP_FILTER_DISCHARGE, OSCILLATOR_HALVING, DELAY_CLOCK_INVERT, BIAS_FORBIDDEN_SEL;
    logic [1:0] OSC_GAIN;
    logic [7:0] DELAY_DEGREES;
    logic [2:0] DELAY_BIAS;
    logic [15:0] CH_A_IN = 16'h1000, CH_B_IN = 16'h0200, CH_A_OUT, CH_B_OUT;
    int num_errors = 0, n_compared = 0;

    // single slave: its ready is the bus ready
    assign HREADY = HREADYOUT;

    pdc_config_regs #(.DATA_W(16)) uut (.CLOCK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY, .HRDATA, .HREADYOUT, .HRESP, .MULT_FACTOR, .REFDIV_FACTOR, .DIVIDER_INVALID,
        .LOOP_FILTER_DISCHARGE, .OSCILLATOR_HALVING, .OSC_GAIN, .OSC_RANGE, .DELAY_CODE, .DELAY_DEGREES,
        .DELAY_CLOCK_INVERT, .DELAY_BIAS, .BIAS_FORBIDDEN_SEL, .CH_A_IN, .CH_B_IN, .CH_A_OUT, .CH_B_OUT);

    // 25 MHz clock
    initial begin
        forever #20 CLOCK = ~CLOCK;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // bounded wait so a stuck slave cannot hang the run
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 20);
        if (HREADYOUT !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t bus hung", $time);
            wrap_up();
        end
    endtask

    // one single-word transfer; read data taken at the data-phase edge
    task automatic xfer(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {25'h0, idx, 2'h0};
        wait_ready();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, wd};
        wait_ready();
        rd = HRDATA;
    endtask

    task automatic rdchk(input logic [4:0] idx, input logic [7:0] exp, input string what);
        xfer(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp}, what);
    endtask

    task automatic t_reset;
        logic [4:0] idx [9] = '{IDX_DIVIDERS, IDX_DELAY, IDX_TUNING, IDX_SYNC_A_HIGH, IDX_A_LOW, IDX_B_HIGH, IDX_B_LOW,
            IDX_CONTROL, IDX_STATUS};
        foreach (idx[i]) rdchk(idx[i], 8'h00, "reset value");
        chk({22'h0, MULT_FACTOR, REFDIV_FACTOR}, {22'h0, 6'h01, 4'h1}, "reset factors");
        chk({24'h0, DELAY_DEGREES}, 32'h5A, "reset degrees");
        xfer(1'b1, 5'h1F, 8'hA5);
        rdchk(5'h1F, 8'h00, "unmapped");
    endtask

    // every thermometer code plus two broken patterns
    // the divide-by-8 entry is what software picks to slow a fast reference
    task automatic t_dividers;
        logic [7:0] code [8] = '{8'h00, 8'h09, 8'h1B, 8'h3F, 8'h78, 8'hF9, 8'h12, 8'h0A};
        logic [5:0] em [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00, 6'h02};
        logic [3:0] en [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h2, 4'h0, 4'h0};
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, IDX_DIVIDERS, code[i]);
            // factors are registered: look at the second edge, before it updates anything
            repeat (2) @(posedge CLOCK);
            chk({22'h0, MULT_FACTOR, REFDIV_FACTOR}, {22'h0, em[i], en[i]}, "factors");
            chk({31'h0, DIVIDER_INVALID}, {31'h0, i >= 6}, "invalid flag");
            rdchk(IDX_DIVIDERS, code[i], "divider readback");
            rdchk(IDX_STATUS, {7'h00, i >= 6}, "status invalid");
        end
    endtask

    // both delay extremes, centre, and the forbidden bias
    // the loop restart after these writes goes through a register outside this bank
    task automatic t_delay;
        logic [7:0] b [4] = '{8'h8B, 8'h70, 8'h0D, 8'hF4};
        logic [7:0] deg [4] = '{8'h32, 8'h7D, 8'h5A, 8'h55};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, IDX_DELAY, b[i]);
            repeat (2) @(posedge CLOCK);
            chk({24'h0, DELAY_DEGREES}, {24'h0, deg[i]}, "degrees");
            chk({24'h0, DELAY_CODE, DELAY_CLOCK_INVERT, DELAY_BIAS}, {24'h0, b[i]}, "delay fields");
            chk({31'h0, BIAS_FORBIDDEN_SEL}, {31'h0, i == 3}, "bias forbidden");
        end
    endtask

    // discharge set then released, then halving, gain and range
    task automatic t_tuning;
        logic [7:0] b [4] = '{8'h80, 8'h00, 8'h47, 8'h30};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, IDX_TUNING, b[i]);
            @(posedge CLOCK);
            chk({24'h0, LOOP_FILTER_DISCHARGE, OSCILLATOR_HALVING, OSC_GAIN, OSC_RANGE}, {24'h0, b[i]}, "tuning");
        end
    endtask

    task automatic settle_out(input logic [15:0] ea, input string what);
        repeat (4) @(posedge CLOCK);
        chk({16'h0, CH_A_OUT}, {16'h0, ea}, what);
    endtask

    // double-buffered offsets: load only on a sync rising edge
    task automatic t_offset;
        xfer(1'b1, IDX_CONTROL, 8'h01);
        xfer(1'b1, IDX_SYNC_A_HIGH, 8'h1F);
        xfer(1'b1, IDX_A_LOW, 8'hFE);
        xfer(1'b1, IDX_B_HIGH, 8'h00);
        xfer(1'b1, IDX_B_LOW, 8'h05);
        settle_out(16'h1000, "before sync");
        xfer(1'b1, IDX_SYNC_A_HIGH, 8'h3F);
        settle_out(16'h0FFE, "after sync");
        chk({16'h0, CH_B_OUT}, 32'h0205, "b after sync");
        rdchk(IDX_WORK_A, 8'h1F, "working a high");
        rdchk(IDX_WORK_B, 8'h00, "working b high");
        rdchk(IDX_B_LOW, 8'h05, "b low readback");
        rdchk(IDX_SYNC_A_HIGH, 8'h3F, "sync kept");
        xfer(1'b1, IDX_A_LOW, 8'h10);
        xfer(1'b1, IDX_SYNC_A_HIGH, 8'h3F);
        settle_out(16'h0FFE, "no edge no load");
        xfer(1'b1, IDX_SYNC_A_HIGH, 8'h1F);
        xfer(1'b1, IDX_SYNC_A_HIGH, 8'h3F);
        settle_out(16'h0F10, "reload");
        xfer(1'b1, IDX_CONTROL, 8'h00);
        settle_out(16'h1000, "offset off");
    endtask

    initial begin
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'b1;
        t_reset();
        t_dividers();
        t_delay();
        t_tuning();
        t_offset();
        wrap_up();
    end
endmodule
